// file: verilog/link_state_ctrl.sv
// top of the operating-state controller: boot copy, eight operation states, uart routing
// assumes baseband and uart framing sit outside; events arrive as one-cycle pulses
`timescale 1ns/1ps
`include "link_state_map.svh"

//Function
//- boot copies store, checks, then operates
//- automatic flag checked at boot, incoming link
//- automatic: try each default entry up to three times
//- automatic off: no autonomous action after boot
//- force master: role switch, drop on failure
//- no force master: accept as slave
//- entry transparent flag switches uart after link
//- transparent flag only with single entry
//- patch copied each boot, replaces rom code
//- service database restored, default if unconfigured
//- command mode except both transparent states
//- incoming link state moves per state
//- outgoing link state moves per state
//- transparent command needs exactly one link
//- break leaves transparent, ignored in scatternet master
//- discoverability follows setting or forced off
//- connectability follows setting or forced off
//- inquiry barred in three states
//- outgoing connects barred in three states
//- slave limits seven, six, two masters
//- scatternet master rejects incoming, transparent command
//- audio link barred in both idle states and scatternet slave
//- idle state after boot and last release
//- transparent mode passes raw data both ways
module link_state_ctrl (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] ee_rdata,
	input wire logic in_link_req,
	input wire logic role_done,
	input wire logic role_ok,
	input wire logic out_link_ok,
	input wire logic out_link_default,
	input wire logic link_release,
	input wire logic release_was_master,
	input wire logic conn_done,
	input wire logic conn_ok,
	input wire logic cmd_valid,
	input wire link_state_pkg::cmd_t cmd_code,
	input wire logic uart_break,
	input wire link_state_pkg::byte_t uart_rx,
	input wire link_state_pkg::byte_t link_rx,
	output logic [5:0] ee_addr,
	output link_state_pkg::byte_t ram_wr,
	output logic [5:0] ram_addr,
	output logic patch_active,
	output logic init_done,
	output logic param_error,
	output link_state_pkg::op_state_t op_state,
	output link_state_pkg::perm_t perm,
	output logic link_accept,
	output logic link_reject,
	output logic role_switch_req,
	output logic auto_conn_req,
	output logic [7:0] auto_conn_idx,
	output logic conf_valid,
	output logic [7:0] conf_status,
	output link_state_pkg::byte_t link_tx,
	output link_state_pkg::byte_t uart_tx,
	output logic uart_tx_raw,
	output link_state_pkg::byte_t cmd_byte
);
	import link_state_pkg::*;

	typedef struct packed {
		op_state_t op;
		logic ready;
		logic [2:0] masters_of;
		logic [1:0] slaves_of;
		logic role_wait;
		perm_t perm;
		logic accept;
		logic reject;
		logic role_req;
		logic auto_start;
		logic conf;
		logic [7:0] status;
		byte_t link_tx;
		byte_t uart_tx;
		logic raw;
		byte_t cmd;
	} ctrl_reg_t;

	logic [1:0] rst_sync;
	logic rst_n;
	ctrl_reg_t r, n;
	settings_t set;
	logic copy_done;
	logic transp_state;
	logic [3:0] links;
	logic transp_eff;
	logic slave_room;
	op_state_t idle_st;

	// reset released through two flops, asserted at once
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	nv_copy_engine u_copy (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.ee_rdata(ee_rdata),
		.ee_addr(ee_addr),
		.ram_wr(ram_wr),
		.ram_addr(ram_addr),
		.settings(set),
		.patch_active(patch_active),
		.done(copy_done),
		.param_error(param_error)
	);

	// automatic start only with the flag on; off means no autonomous step
	auto_connect_seq u_auto (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.start(r.auto_start),
		.entry_count(set.default_count),
		.conn_done(conn_done),
		.conn_ok(conn_ok),
		.conn_req(auto_conn_req),
		.conn_idx(auto_conn_idx),
		.busy()
	);

	// helper terms shared by the state logic
	assign links = {1'b0, r.masters_of} + {2'b00, r.slaves_of};
	assign transp_state = (r.op == ST_TRANSP_MASTER) || (r.op == ST_TRANSP_SLAVE);
	assign transp_eff = set.transp_flag && (set.default_count == `ONE_ENTRY);
	assign idle_st = set.auto_on ? ST_IDLE_AUTO : ST_IDLE_MAN;
	assign slave_room = (r.op == ST_SCAT_MASTER) ? (r.masters_of < `SCAT_MAX_SLAVES)
		: (r.masters_of < `PICO_MAX_SLAVES);

	// events are expected one per cycle; break, release, role result, link, command
	always_comb begin
		n = r;
		n.accept = 1'b0;
		n.reject = 1'b0;
		n.role_req = 1'b0;
		n.auto_start = 1'b0;
		n.conf = 1'b0;
		n.link_tx.valid = 1'b0;
		n.uart_tx.valid = 1'b0;
		n.cmd.valid = 1'b0;
		if (!r.ready) begin
			// nothing operates until the copy has finished
			if (copy_done) begin
				n.ready = 1'b1;
				n.op = idle_st;
				n.auto_start = set.auto_on;
			end
		end else if (uart_break && transp_state) begin
			n.op = (r.op == ST_TRANSP_MASTER) ? ST_PICO_MASTER : ST_SINGLE_SLAVE;
		end else if (link_release) begin
			if (release_was_master && r.masters_of != 3'h0)
				n.masters_of = r.masters_of - 3'h1;
			if (!release_was_master && r.slaves_of != 2'h0)
				n.slaves_of = r.slaves_of - 2'h1;
			if (links <= 4'h1)
				n.op = idle_st;
			else if (r.op == ST_SCAT_MASTER && !release_was_master)
				n.op = ST_PICO_MASTER;
			else if (r.op == ST_SCAT_MASTER && r.masters_of == 3'h1)
				n.op = ST_SINGLE_SLAVE;
			else if (r.op == ST_SCAT_SLAVE)
				n.op = ST_SINGLE_SLAVE;
		end else if (role_done && r.role_wait) begin
			n.role_wait = 1'b0;
			if (role_ok && slave_room) begin
				n.accept = 1'b1;
				n.masters_of = r.masters_of + 3'h1;
				n.op = (r.op == ST_SINGLE_SLAVE) ? ST_SCAT_MASTER : ST_PICO_MASTER;
			end else begin
				n.reject = 1'b1;
			end
		end else if (in_link_req) begin
			// only idle, piconet master and single slave take a new link
			if (r.role_wait || !r.perm.connectable || r.op == ST_SCAT_MASTER) begin
				n.reject = 1'b1;
			end else if (set.force_master) begin
				n.role_req = 1'b1;
				n.role_wait = 1'b1;
			end else begin
				n.accept = 1'b1;
				n.slaves_of = r.slaves_of + 2'h1;
				unique case (r.op)
					ST_IDLE_AUTO: n.op = ST_TRANSP_SLAVE;
					ST_IDLE_MAN: n.op = ST_SINGLE_SLAVE;
					ST_PICO_MASTER: n.op = ST_SCAT_MASTER;
					default: n.op = ST_SCAT_SLAVE;
				endcase
				if (r.op == ST_IDLE_AUTO || r.op == ST_IDLE_MAN)
					n.op = set.auto_on ? ST_TRANSP_SLAVE : ST_SINGLE_SLAVE;
			end
		end else if (out_link_ok && r.perm.connect_ok) begin
			n.masters_of = r.masters_of + 3'h1;
			if (r.op == ST_SCAT_MASTER || r.op == ST_SINGLE_SLAVE)
				n.op = ST_SCAT_MASTER;
			else if (out_link_default && transp_eff && links == 4'h0)
				n.op = ST_TRANSP_MASTER;
			else
				n.op = ST_PICO_MASTER;
		end else if (cmd_valid) begin
			n.conf = 1'b1;
			n.status = `STATUS_NOT_APPLICABLE;
			unique case (cmd_code)
				CMD_TRANSPARENT: begin
					if ((r.op == ST_PICO_MASTER || r.op == ST_SINGLE_SLAVE) && links == 4'h1) begin
						n.status = `STATUS_OK;
						n.op = (r.op == ST_PICO_MASTER) ? ST_TRANSP_MASTER : ST_TRANSP_SLAVE;
					end
				end
				CMD_CONNECT: begin
					if (r.perm.connect_ok)
						n.status = `STATUS_OK;
				end
				CMD_INQUIRY: begin
					if (r.perm.inquiry_ok)
						n.status = `STATUS_OK;
				end
				CMD_SCO: begin
					if (r.perm.sco_ok)
						n.status = `STATUS_OK;
				end
			endcase
		end

		// permissions follow the state being entered
		n.perm.uart_transparent = (n.op == ST_TRANSP_MASTER) || (n.op == ST_TRANSP_SLAVE);
		n.perm.raw_ok = n.perm.uart_transparent;
		n.perm.discoverable = n.ready && set.discover_en && !n.perm.uart_transparent
			&& (n.op != ST_SCAT_SLAVE);
		n.perm.connectable = n.ready && set.connect_en && (n.op == ST_IDLE_AUTO
			|| n.op == ST_IDLE_MAN || n.op == ST_PICO_MASTER || n.op == ST_SINGLE_SLAVE);
		n.perm.inquiry_ok = n.ready && !n.perm.uart_transparent && (n.op != ST_SCAT_SLAVE);
		n.perm.connect_ok = n.perm.inquiry_ok
			&& ((n.op == ST_SCAT_MASTER) ? (n.masters_of < `SCAT_MAX_SLAVES)
			: (n.masters_of < `PICO_MAX_SLAVES));
		n.perm.sco_ok = n.ready && (n.op == ST_PICO_MASTER || n.op == ST_SCAT_MASTER
			|| n.op == ST_TRANSP_MASTER || n.op == ST_SINGLE_SLAVE
			|| n.op == ST_TRANSP_SLAVE);

		// raw pass-through in transparent mode, otherwise command bytes and events
		if (r.perm.uart_transparent) begin
			n.link_tx = uart_rx;
		end else begin
			n.cmd = uart_rx;
		end
		n.uart_tx = link_rx;
		n.raw = r.perm.uart_transparent;
	end

	// whole state registered in one place; idle-manual until settings are known
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{op: ST_IDLE_MAN, ready: 1'b0, masters_of: 3'h0, slaves_of: 2'h0,
				role_wait: 1'b0, perm: '0, accept: 1'b0, reject: 1'b0, role_req: 1'b0,
				auto_start: 1'b0, conf: 1'b0, status: `STATUS_OK, link_tx: '0,
				uart_tx: '0, raw: 1'b0, cmd: '0};
		end else begin
			r <= n;
		end
	end

	assign init_done = r.ready;
	assign op_state = r.op;
	assign perm = r.perm;
	assign link_accept = r.accept;
	assign link_reject = r.reject;
	assign role_switch_req = r.role_req;
	assign conf_valid = r.conf;
	assign conf_status = r.status;
	assign link_tx = r.link_tx;
	assign uart_tx = r.uart_tx;
	assign uart_tx_raw = r.raw;
	assign cmd_byte = r.cmd;

	a_no_ops_early: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!r.ready |-> !r.perm.connect_ok && !r.perm.inquiry_ok && !r.accept)
		else $error("operation before initialization");
	a_uart_mode: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.perm.uart_transparent == (r.op == ST_TRANSP_MASTER || r.op == ST_TRANSP_SLAVE))
		else $error("uart mode does not match state");
	a_break_master: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.ready && r.op == ST_TRANSP_MASTER && uart_break |=> r.op == ST_PICO_MASTER)
		else $error("break did not leave transparent master");
	a_break_scat: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.op == ST_SCAT_MASTER && uart_break && !link_release && !role_done
		&& !in_link_req && !out_link_ok && !cmd_valid |=> r.op == ST_SCAT_MASTER)
		else $error("break changed scatternet master");
	a_disc_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r.op == ST_TRANSP_MASTER || r.op == ST_SCAT_SLAVE || r.op == ST_TRANSP_SLAVE)
		|-> !r.perm.discoverable && !r.perm.inquiry_ok && !r.perm.connect_ok)
		else $error("discover or inquiry allowed in barred state");
	a_conn_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.op == ST_SCAT_MASTER |-> !r.perm.connectable)
		else $error("scatternet master connectable");
	a_sco_scat_slave: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.op == ST_SCAT_SLAVE |-> !r.perm.sco_ok)
		else $error("audio allowed as scatternet slave");
	a_scat_reject: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.ready && r.op == ST_SCAT_MASTER && in_link_req && !uart_break && !link_release
		&& !(role_done && r.role_wait) |=> link_reject && !link_accept)
		else $error("scatternet master took an incoming link");
	a_na_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		conf_valid && conf_status != `STATUS_OK |-> r.op == $past(r.op))
		else $error("refused command changed state");
	a_slave_limit: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.masters_of <= `PICO_MAX_SLAVES && r.slaves_of <= 2'h2)
		else $error("link count above limit");
	// a result in the very next cycle is legal, so only a silent partner is checked
	a_force_req: assert property (@(posedge clk_sys) disable iff (!rst_n)
		role_switch_req && !role_done |-> r.role_wait ##1 !link_accept)
		else $error("role switch request without wait");
	// routing follows the mode that was registered one cycle earlier
	a_raw_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
		link_tx.valid |-> uart_tx_raw)
		else $error("raw byte sent to link in command mode");
	a_cmd_route: assert property (@(posedge clk_sys) disable iff (!rst_n)
		cmd_byte.valid |-> !uart_tx_raw)
		else $error("command byte passed in transparent mode");
	a_transp_links: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.perm.uart_transparent |-> links == 4'h1)
		else $error("transparent mode without exactly one link");

	c_transp_master: cover property (@(posedge clk_sys) disable iff (!rst_n)
		r.op == ST_TRANSP_MASTER);
	c_scat_slave: cover property (@(posedge clk_sys) disable iff (!rst_n)
		r.op == ST_SCAT_SLAVE);
	c_refused: cover property (@(posedge clk_sys) disable iff (!rst_n)
		conf_valid && conf_status == `STATUS_NOT_APPLICABLE);
	c_role_fail: cover property (@(posedge clk_sys) disable iff (!rst_n)
		role_switch_req ##[1:20] link_reject);
endmodule

// file: verilog/link_state_map.svh
// constants of the operating-state controller: nonvolatile layout, counts, status codes
// assumes a byte-wide nonvolatile store with one-cycle read latency
`ifndef LINK_STATE_MAP_SVH
`define LINK_STATE_MAP_SVH

// nonvolatile settings block, byte offsets
`define NV_AUTO_OFS 6'h00
`define NV_FORCE_OFS 6'h01
`define NV_DISC_OFS 6'h02
`define NV_CONN_OFS 6'h03
`define NV_DEFCNT_OFS 6'h04
`define NV_TRANSP_OFS 6'h05
`define NV_ADDR_FIRST 6'h06
`define NV_ADDR_LAST 6'h0b
// service database and patch regions
`define SDB_FIRST 6'h10
`define SDB_LAST 6'h1f
`define PATCH_FIRST 6'h20
`define COPY_LAST 6'h2f

// byte values
`define BYTE_ERASED 8'hff
`define SDB_DEFAULT 8'h00
`define FLAG_ON 8'h01
`define FLAG_OFF 8'h00

// counts
`define CONNECT_TRIES 2'h3
`define PICO_MAX_SLAVES 3'h7
`define SCAT_MAX_SLAVES 3'h6
`define ONE_ENTRY 8'h01

// confirmation status
`define STATUS_OK 8'h00
`define STATUS_NOT_APPLICABLE 8'h0c

`endif

// file: verilog/link_state_pkg.sv
// types shared by the operating-state controller and its helpers
// assumes link_state_map.svh supplies the numeric constants
package link_state_pkg;
	typedef enum logic [7:0] {
		ST_IDLE_AUTO = 8'h01,
		ST_IDLE_MAN = 8'h02,
		ST_PICO_MASTER = 8'h04,
		ST_SCAT_MASTER = 8'h08,
		ST_TRANSP_MASTER = 8'h10,
		ST_SINGLE_SLAVE = 8'h20,
		ST_SCAT_SLAVE = 8'h40,
		ST_TRANSP_SLAVE = 8'h80
	} op_state_t;

	typedef enum logic [1:0] {
		CMD_TRANSPARENT = 2'h0,
		CMD_CONNECT = 2'h1,
		CMD_INQUIRY = 2'h2,
		CMD_SCO = 2'h3
	} cmd_t;

	typedef enum logic [2:0] {
		CP_READ = 3'h1,
		CP_WRITE = 3'h2,
		CP_DONE = 3'h4
	} copy_state_t;

	typedef enum logic [3:0] {
		AS_IDLE = 4'h1,
		AS_REQ = 4'h2,
		AS_WAIT = 4'h4,
		AS_DONE = 4'h8
	} auto_state_t;

	typedef struct packed {
		logic auto_on;
		logic force_master;
		logic discover_en;
		logic connect_en;
		logic [7:0] default_count;
		logic transp_flag;
	} settings_t;

	typedef struct packed {
		logic uart_transparent;
		logic discoverable;
		logic connectable;
		logic inquiry_ok;
		logic connect_ok;
		logic raw_ok;
		logic sco_ok;
	} perm_t;

	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} byte_t;
endpackage

// file: verilog/nv_copy_engine.sv
// boot-time copy of nonvolatile settings, service database and patch code into ram
// assumes the store returns ee_rdata one cycle after ee_addr
`timescale 1ns/1ps
`include "link_state_map.svh"
module nv_copy_engine (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] ee_rdata,
	output logic [5:0] ee_addr,
	output link_state_pkg::byte_t ram_wr,
	output logic [5:0] ram_addr,
	output link_state_pkg::settings_t settings,
	output logic patch_active,
	output logic done,
	output logic param_error
);
	import link_state_pkg::*;

	typedef struct packed {
		copy_state_t st;
		logic [5:0] addr;
		logic sdb_default;
		logic addr_erased;
		byte_t wr;
		logic [5:0] wr_addr;
		settings_t set;
		logic patch;
		logic done;
		logic err;
	} copy_reg_t;

	copy_reg_t r, n;
	logic [7:0] wdata;
	logic in_sdb;

	// one byte per two cycles: present address, then store what came back
	always_comb begin
		n = r;
		n.wr.valid = 1'b0;
		in_sdb = (r.addr >= `SDB_FIRST) && (r.addr <= `SDB_LAST);
		wdata = ee_rdata;
		unique case (r.st)
			CP_READ: begin
				n.st = CP_WRITE;
			end
			CP_WRITE: begin
				// erased marker means never configured: default contents
				if (r.addr == `SDB_FIRST && ee_rdata == `BYTE_ERASED)
					n.sdb_default = 1'b1;
				if (in_sdb && (r.sdb_default || (r.addr == `SDB_FIRST && ee_rdata == `BYTE_ERASED)))
					wdata = `SDB_DEFAULT;
				n.wr.valid = 1'b1;
				n.wr.data = wdata;
				n.wr_addr = r.addr;
				if (r.addr == `NV_AUTO_OFS)
					n.set.auto_on = (ee_rdata == `FLAG_ON);
				if (r.addr == `NV_FORCE_OFS)
					n.set.force_master = (ee_rdata == `FLAG_ON);
				if (r.addr == `NV_DISC_OFS)
					n.set.discover_en = (ee_rdata == `FLAG_ON);
				if (r.addr == `NV_CONN_OFS)
					n.set.connect_en = (ee_rdata == `FLAG_ON);
				if (r.addr == `NV_DEFCNT_OFS)
					n.set.default_count = ee_rdata;
				if (r.addr == `NV_TRANSP_OFS)
					n.set.transp_flag = (ee_rdata == `FLAG_ON);
				// device address must hold at least one programmed byte
				if (r.addr >= `NV_ADDR_FIRST && r.addr <= `NV_ADDR_LAST)
					n.addr_erased = r.addr_erased && (ee_rdata == `BYTE_ERASED);
				// patch copied every boot; a marker byte other than erased enables it
				if (r.addr == `PATCH_FIRST)
					n.patch = (ee_rdata != `BYTE_ERASED);
				if (r.addr == `COPY_LAST) begin
					n.st = CP_DONE;
				end else begin
					n.addr = r.addr + 6'h01;
					n.st = CP_READ;
				end
			end
			CP_DONE: begin
				// a missing address keeps the device out of operation until reset
				n.done = !r.addr_erased;
				n.err = r.addr_erased;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{st: CP_READ, addr: 6'h00, sdb_default: 1'b0, addr_erased: 1'b1,
				wr: '0, wr_addr: 6'h00, set: '0, patch: 1'b0, done: 1'b0, err: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign ee_addr = r.addr;
	assign ram_wr = r.wr;
	assign ram_addr = r.wr_addr;
	assign settings = r.set;
	assign patch_active = r.patch;
	assign done = r.done;
	assign param_error = r.err;

	a_done_after_copy: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(r.done) |-> $past(r.st) == CP_DONE && !r.err)
		else $error("operation entered without completed copy");
	a_sdb_default: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(r.st == CP_WRITE && r.sdb_default && r.addr <= `SDB_LAST && r.addr >= `SDB_FIRST)
		|=> r.wr.valid && r.wr.data == `SDB_DEFAULT)
		else $error("unconfigured service database not defaulted");
endmodule

// file: verilog/auto_connect_seq.sv
// walks the default-connection table after boot, up to three attempts per entry
// assumes conn_done pulses once per request from the baseband
`timescale 1ns/1ps
`include "link_state_map.svh"
module auto_connect_seq (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic start,
	input wire logic [7:0] entry_count,
	input wire logic conn_done,
	input wire logic conn_ok,
	output logic conn_req,
	output logic [7:0] conn_idx,
	output logic busy
);
	import link_state_pkg::*;

	typedef struct packed {
		auto_state_t st;
		logic [7:0] idx;
		logic [1:0] tries;
		logic req;
	} seq_reg_t;

	seq_reg_t r, n;

	// next entry on success or after the last failed try
	always_comb begin
		n = r;
		n.req = 1'b0;
		unique case (r.st)
			AS_IDLE: begin
				if (start) begin
					n.idx = 8'h00;
					n.tries = 2'h0;
					n.st = (entry_count == 8'h00) ? AS_DONE : AS_REQ;
				end
			end
			AS_REQ: begin
				n.req = 1'b1;
				n.tries = r.tries + 2'h1;
				n.st = AS_WAIT;
			end
			AS_WAIT: begin
				if (conn_done) begin
					if (conn_ok || r.tries == `CONNECT_TRIES) begin
						n.tries = 2'h0;
						n.idx = r.idx + 8'h01;
						n.st = (r.idx + 8'h01 == entry_count) ? AS_DONE : AS_REQ;
					end else begin
						n.st = AS_REQ;
					end
				end
			end
			AS_DONE: begin
				n.st = AS_DONE;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{st: AS_IDLE, idx: 8'h00, tries: 2'h0, req: 1'b0};
		end else begin
			r <= n;
		end
	end

	assign conn_req = r.req;
	assign conn_idx = r.idx;
	assign busy = (r.st == AS_REQ) || (r.st == AS_WAIT);

	a_tries_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
		r.st == AS_WAIT |-> r.tries >= 2'h1 && r.tries <= `CONNECT_TRIES)
		else $error("attempt count out of range");
	c_retry: cover property (@(posedge clk_sys) disable iff (!rst_n)
		r.req && r.tries == 2'h3);
endmodule

// file: verif/nv_store_model.sv
// nonvolatile store model that answers the controller's boot copy
// assumes the bench loads mem before it releases reset
`timescale 1ns/1ps
module nv_store_model (
	input wire logic clk_sys,
	input wire logic [5:0] ee_addr,
	output logic [7:0] ee_rdata
);
	logic [7:0] mem [64];
	// one-cycle read latency, always selected, so no released-bus case
	always_ff @(posedge clk_sys) begin
		ee_rdata <= mem[ee_addr];
	end
endmodule

// file: verif/tb.sv
// testbench of the operating-state controller: boot copy, state moves, permissions, routing
// assumes nv_store_model as store; inputs change on the falling edge
`timescale 1ns/1ps
module tb;
	import link_state_pkg::*;
	logic clk_sys = 0, reset_n = 0, in_link_req = 0, role_done = 0, role_ok = 0;
	logic out_link_ok = 0, out_link_default = 0, link_release = 0, release_was_master = 0;
	logic conn_done = 0, conn_ok = 0, cmd_valid = 0, uart_break = 0, d, c;
	cmd_t cmd_code = CMD_TRANSPARENT;
	byte_t uart_rx = '0, link_rx = '0, ram_wr, link_tx, uart_tx, cmd_byte;
	logic [7:0] ee_rdata, auto_conn_idx, conf_status;
	logic [5:0] ee_addr, ram_addr;
	logic patch_active, init_done, param_error, link_accept, link_reject, role_switch_req;
	logic auto_conn_req, conf_valid, uart_tx_raw;
	op_state_t op_state;
	perm_t perm;
	int n_errors = 0, tests_run = 0, cyc = 0, n_req = 0, n_wr = 0;
	logic [7:0] ram_copy [64];
	link_state_ctrl i_dut (.clk_sys, .reset_n, .ee_rdata, .in_link_req, .role_done, .role_ok,
		.out_link_ok, .out_link_default, .link_release, .release_was_master, .conn_done,
		.conn_ok, .cmd_valid, .cmd_code, .uart_break, .uart_rx, .link_rx, .ee_addr, .ram_wr,
		.ram_addr, .patch_active, .init_done, .param_error, .op_state, .perm, .link_accept,
		.link_reject, .role_switch_req, .auto_conn_req, .auto_conn_idx, .conf_valid,
		.conf_status, .link_tx, .uart_tx, .uart_tx_raw, .cmd_byte);
	nv_store_model i_nv (.clk_sys, .ee_addr, .ee_rdata);
	initial begin
		forever #20 clk_sys = ~clk_sys;
	end
	// sampled mid-cycle so registered pulses are settled and seen once
	always @(negedge clk_sys) begin
		cyc++;
		if (ram_wr.valid === 1'b1) begin
			ram_copy[ram_addr] = ram_wr.data;
			n_wr++;
		end
		if (auto_conn_req === 1'b1) n_req++;
		if (cyc == 5000) begin
			n_errors++;
			results();
		end
	end
	task results;
		if (n_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input logic [8:0] g, input logic [8:0] e);
		tests_run++;
		if (g !== e) begin
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
			n_errors++;
		end
	endtask
	// permission levels per state, built from the stored settings d and c
	function logic [6:0] pexp(input logic [7:0] s);
		case (s)
			8'h01, 8'h02: pexp = {1'b0, d, c, 4'hc};
			8'h04, 8'h20: pexp = {1'b0, d, c, 4'hd};
			8'h08: pexp = {1'b0, d, 5'h0d};
			8'h10, 8'h80: pexp = 7'h43;
			default: pexp = 7'h00;
		endcase
	endfunction
	// codes: 0 incoming, 1 outgoing, 2 break, 3..6 commands, 7 release
	task automatic ev(input int k, input logic x, input logic [7:0] st);
		logic [6:0] e;
		@(negedge clk_sys);
		case (k)
			0: in_link_req = 1;
			1: {out_link_ok, out_link_default} = {1'b1, x};
			2: uart_break = 1;
			7: {link_release, release_was_master} = {1'b1, x};
			default: begin
				cmd_valid = 1;
				cmd_code = cmd_t'(k - 3);
			end
		endcase
		@(negedge clk_sys);
		{in_link_req, out_link_ok, uart_break, link_release, cmd_valid} = '0;
		e = pexp(st);
		chk(op_state, st);
		// idle audio permission left open; skipped after outgoing, where the limit may gate it
		if (k != 1 && st < 8'h04) chk(perm[6:1], e[6:1]);
		else if (k != 1) chk(perm, e);
	endtask
	task automatic dat(input logic tr);
		@(negedge clk_sys);
		{uart_rx, link_rx} = {1'b1, 8'h5a, 1'b1, 8'ha5};
		@(negedge clk_sys);
		{uart_rx, link_rx} = '0;
		chk(tr ? link_tx : cmd_byte, 9'h15a);
		chk(tr ? cmd_byte.valid : link_tx.valid, 9'h000);
		chk(uart_tx, 9'h1a5);
		chk(uart_tx_raw, tr);
	endtask
	task automatic boot(input logic [7:0] a, f, cnt, dc, sv, pv);
		for (int k = 0; k < 64; k++) i_nv.mem[k] = 8'(k);
		{i_nv.mem[0], i_nv.mem[1], i_nv.mem[2], i_nv.mem[3]} = {a, f, dc, dc};
		{i_nv.mem[4], i_nv.mem[5], i_nv.mem[16], i_nv.mem[32]} = {cnt, 8'h01, sv, pv};
		d = (dc == 8'h01);
		c = d;
		@(negedge clk_sys);
		reset_n = 0;
		repeat (12) @(negedge clk_sys);
		{n_wr, n_req, reset_n} = {32'h0, 32'h0, 1'b1};
		for (int k = 0; k < 400 && init_done !== 1'b1; k++) @(negedge clk_sys);
		chk(9'(n_wr), 9'h030);
		chk(param_error, 9'h000);
		for (int k = 0; k < 48; k++)
			chk(ram_copy[k], (k > 15 && k < 32 && sv == 8'hff) ? 8'h00 : i_nv.mem[k]);
		chk(patch_active, pv != 8'hff);
		chk(op_state, a == 8'h01 ? 9'h001 : 9'h002);
	endtask
	task automatic areq(input logic [7:0] idx, input logic ok);
		for (int k = 0; k < 50 && auto_conn_req !== 1'b1; k++) @(negedge clk_sys);
		chk(auto_conn_req, 9'h001);
		chk(auto_conn_idx, idx);
		{conn_done, conn_ok} = {1'b1, ok};
		@(negedge clk_sys);
		conn_done = 0;
	endtask
	initial begin
		boot(8'h00, 8'h00, 8'h01, 8'h01, 8'hff, 8'hab);
		repeat (20) @(negedge clk_sys);
		chk(9'(n_req), 9'h000);
		ev(1, 0, 8'h04);
		ev(3, 0, 8'h10);
		dat(1);
		ev(2, 0, 8'h04);
		for (int k = 0; k < 7; k++) ev(1, 0, 8'h04);
		for (int k = 0; k < 6; k++) ev(7, 1, 8'h04);
		ev(7, 1, 8'h02);
		ev(0, 0, 8'h20);
		chk({link_accept, role_switch_req}, 9'h002);
		dat(0);
		ev(3, 0, 8'h80);
		chk({conf_valid, conf_status}, 9'h100);
		ev(2, 0, 8'h20);
		ev(1, 0, 8'h08);
		ev(0, 0, 8'h08);
		chk(link_reject, 9'h001);
		ev(3, 0, 8'h08);
		chk({conf_valid, conf_status}, 9'h10c);
		ev(2, 0, 8'h08);
		ev(7, 1, 8'h20);
		ev(0, 0, 8'h40);
		for (int k = 4; k < 7; k++) begin
			ev(k, 0, 8'h40);
			chk(conf_status, 9'h00c);
		end
		ev(7, 0, 8'h20);
		ev(7, 0, 8'h02);
		ev(1, 0, 8'h04);
		ev(0, 0, 8'h08);
		for (int k = 4; k < 7; k++) begin
			ev(k, 0, 8'h08);
			chk({conf_valid, conf_status}, 9'h100);
		end
		boot(8'h01, 8'h01, 8'h02, 8'h00, 8'h5a, 8'hff);
		for (int k = 0; k < 6; k++) areq(8'(k / 3), 0);
		repeat (30) @(negedge clk_sys);
		chk(9'(n_req), 9'h006);
		ev(0, 0, 8'h01);
		chk(link_reject, 9'h001);
		ev(1, 1, 8'h04);
		boot(8'h00, 8'h01, 8'h01, 8'h01, 8'h5a, 8'hff);
		ev(1, 0, 8'h04);
		for (int j = 1; j >= 0; j--) begin
			@(negedge clk_sys);
			in_link_req = 1;
			@(negedge clk_sys);
			in_link_req = 0;
			chk(role_switch_req, 9'h001);
			{role_done, role_ok} = {1'b1, j[0]};
			@(negedge clk_sys);
			role_done = 0;
			chk({op_state, j[0] ? link_accept : link_reject}, 9'h009);
		end
		boot(8'h01, 8'h00, 8'h01, 8'h01, 8'h5a, 8'hff);
		areq(8'h00, 1);
		ev(1, 1, 8'h10);
		ev(2, 0, 8'h04);
		ev(7, 1, 8'h01);
		ev(0, 0, 8'h80);
		results();
	end
endmodule
